// ==== common/tic_consts.vh ====
`ifndef TIC_CONSTS_VH
`define TIC_CONSTS_VH
// clock and time base
`define TIC_CLK_MHZ 20
`define TIC_TICK_CYC 5'd20
`define TIC_TICK_W 5
// debounce: microseconds, up to about one second
`define TIC_DEB_W 20
`define TIC_DEB_MAX_US 20'hf4240
// trigger delay: microseconds, 0 .. 10000000
`define TIC_DLY_W 24
`define TIC_DLY_MAX_US 24'h989680
// register byte offsets
`define TIC_OFF_CTRL 12'h000
`define TIC_OFF_DEB_SEL 12'h004
`define TIC_OFF_DEB_TIME 12'h008
`define TIC_OFF_DLY 12'h00c
`define TIC_OFF_STATUS 12'h010
`define TIC_OFF_IRQ_STAT 12'h014
`define TIC_OFF_IRQ_MASK 12'h018
`define TIC_OFF_SW_TRIG 12'h01c
`define TIC_OFF_LINES 12'h020
// control fields
`define TIC_CTRL_FREE_RUN 0
`define TIC_CTRL_SRC_HW 1
`define TIC_CTRL_ACQ_EN 2
`define TIC_CTRL_STAT_SEL_LO 4
`define TIC_CTRL_STAT_SEL_HI 5
`define TIC_STAT_SEL_FTW 2'h0
// interrupt status bits
`define TIC_IRQ_TRIG 0
`define TIC_IRQ_READY 1
`define TIC_IRQ_LINE1 2
`define TIC_IRQ_LINE2 3
`define TIC_IRQ_W 4
`define TIC_NUM_LINES 2
`endif

// ==== rtl/tic_debounce.v ====
`timescale 1ns/100ps
`include "tic_consts.vh"

module tic_debounce (
	input wire clk_sys,
	input wire rst_n,
	input wire tick_us,
	input wire line_sync,
	input wire [`TIC_DEB_W-1:0] deb_time,
	output reg line_out_reg,
	output reg edge_out_reg
);
// ========================================
// stable-time filter
// ========================================
reg last_raw_reg;
reg [`TIC_DEB_W-1:0] cnt_reg;

// the first tick after a change may come at once, so one tick more than
// deb_time is waited: the level has stood at least deb_time, at most 1 us more
always @(posedge clk_sys) begin
	if (!rst_n) begin
		last_raw_reg <= 1'b0;
		cnt_reg <= {`TIC_DEB_W{1'b0}};
		line_out_reg <= 1'b0;
		edge_out_reg <= 1'b0;
	end else begin
		edge_out_reg <= 1'b0;
		last_raw_reg <= line_sync;
		if (line_sync != last_raw_reg) begin
			cnt_reg <= {`TIC_DEB_W{1'b0}};
		end else if (line_sync != line_out_reg) begin
			if ((cnt_reg > deb_time) || (deb_time == {`TIC_DEB_W{1'b0}})) begin
				line_out_reg <= line_sync;
				edge_out_reg <= line_sync;
			end else if (tick_us) begin
				cnt_reg <= cnt_reg + 1'b1;
			end
		end else begin
			cnt_reg <= {`TIC_DEB_W{1'b0}};
		end
	end
end

endmodule // tic_debounce

// ==== rtl/tic_trigger_cond.v ====
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/100ps
`include "tic_consts.vh"

// Overview of operation
// - a new input level is accepted only after holding for the debounce time
// - pulses shorter than the debounce time are dropped entirely
// - accepted edges are delayed from the pin by the debounce time
// - debounce time is in microseconds, from zero to about one second
// - each input line has its own debounce time, chosen by a selector
// - hardware triggers wait a programmable 0 to 10000000 microseconds
// - a zero delay lets the hardware trigger act at once
// - software triggers bypass the trigger delay; free-run mode blocks all triggers
// - with frame-trigger-wait selected, status shows trigger readiness for either trigger source
// - acquisition start has no readable status
module tic_trigger_cond (
	input wire clk_sys,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output wire pready,
	output reg [31:0] prdata,
	output wire pslverr,
	input wire [1:0] line_in,
	input wire frame_busy,
	output reg frame_trigger_reg,
	output wire irq
);
// ========================================
// microsecond tick
// ========================================
reg [`TIC_TICK_W-1:0] pre_reg;
reg tick_us_reg;

always @(posedge clk_sys) begin
	if (!rst_n) begin
		pre_reg <= {`TIC_TICK_W{1'b0}};
		tick_us_reg <= 1'b0;
	end else if (pre_reg == `TIC_TICK_CYC - 1'b1) begin
		pre_reg <= {`TIC_TICK_W{1'b0}};
		tick_us_reg <= 1'b1;
	end else begin
		pre_reg <= pre_reg + 1'b1;
		tick_us_reg <= 1'b0;
	end
end

// ========================================
// registers
// ========================================
reg [5:0] ctrl_reg;
reg deb_sel_reg;
reg [`TIC_DEB_W-1:0] deb_time_reg [0:`TIC_NUM_LINES-1];
reg [`TIC_DLY_W-1:0] dly_reg;
reg [`TIC_IRQ_W-1:0] irq_stat_reg;
reg [`TIC_IRQ_W-1:0] irq_mask_reg;
reg sw_trig_reg;
wire access = psel && penable;
wire wr = access && pwrite;
wire trig_ready;
wire [`TIC_NUM_LINES-1:0] line_db;
wire [`TIC_NUM_LINES-1:0] line_edge;
wire [`TIC_IRQ_W-1:0] irq_events;
wire [31:0] wdeb = (pwdata[31:0] > {12'h000, `TIC_DEB_MAX_US}) ?
	{12'h000, `TIC_DEB_MAX_US} : pwdata;
wire [31:0] wdly = (pwdata[31:0] > {8'h00, `TIC_DLY_MAX_US}) ?
	{8'h00, `TIC_DLY_MAX_US} : pwdata;

assign pready = 1'b1;
assign pslverr = 1'b0;

always @(posedge clk_sys) begin
	if (!rst_n) begin
		ctrl_reg <= 6'h00;
		deb_sel_reg <= 1'b0;
		deb_time_reg[0] <= {`TIC_DEB_W{1'b0}};
		deb_time_reg[1] <= {`TIC_DEB_W{1'b0}};
		dly_reg <= {`TIC_DLY_W{1'b0}};
		irq_mask_reg <= {`TIC_IRQ_W{1'b0}};
		sw_trig_reg <= 1'b0;
	end else begin
		sw_trig_reg <= 1'b0;
		if (wr) begin
			case (paddr)
				`TIC_OFF_CTRL: ctrl_reg <= pwdata[5:0];
				`TIC_OFF_DEB_SEL: deb_sel_reg <= pwdata[0];
				`TIC_OFF_DEB_TIME: deb_time_reg[deb_sel_reg] <= wdeb[`TIC_DEB_W-1:0];
				`TIC_OFF_DLY: dly_reg <= wdly[`TIC_DLY_W-1:0];
				`TIC_OFF_IRQ_MASK: irq_mask_reg <= pwdata[`TIC_IRQ_W-1:0];
				`TIC_OFF_SW_TRIG: sw_trig_reg <= pwdata[0];
				default: ;
			endcase
		end
	end
end

// set wins over the write-one clear
always @(posedge clk_sys) begin
	if (!rst_n) begin
		irq_stat_reg <= {`TIC_IRQ_W{1'b0}};
	end else if (wr && paddr == `TIC_OFF_IRQ_STAT) begin
		irq_stat_reg <= (irq_stat_reg & ~pwdata[`TIC_IRQ_W-1:0]) | irq_events;
	end else begin
		irq_stat_reg <= irq_stat_reg | irq_events;
	end
end

assign irq = |(irq_stat_reg & irq_mask_reg);

// status reads: acquisition start has no selector code, so only the
// frame-trigger-wait selection returns a live flag
wire [1:0] stat_sel = ctrl_reg[`TIC_CTRL_STAT_SEL_HI:`TIC_CTRL_STAT_SEL_LO];
wire trigger_ready_flag = (stat_sel == `TIC_STAT_SEL_FTW) ? trig_ready : 1'b0;

always @* begin
	prdata = 32'h0000_0000;
	case (paddr)
		`TIC_OFF_CTRL: prdata = {26'h0, ctrl_reg};
		`TIC_OFF_DEB_SEL: prdata = {31'h0, deb_sel_reg};
		`TIC_OFF_DEB_TIME: prdata = {12'h0, deb_time_reg[deb_sel_reg]};
		`TIC_OFF_DLY: prdata = {8'h0, dly_reg};
		`TIC_OFF_STATUS: prdata = {31'h0, trigger_ready_flag};
		`TIC_OFF_IRQ_STAT: prdata = {28'h0, irq_stat_reg};
		`TIC_OFF_IRQ_MASK: prdata = {28'h0, irq_mask_reg};
		`TIC_OFF_LINES: prdata = {30'h0, line_db};
		default: prdata = 32'h0000_0000;
	endcase
end

// ========================================
// input lines
// ========================================
reg [1:0] sync1_reg;
reg [1:0] sync2_reg;

always @(posedge clk_sys) begin
	if (!rst_n) begin
		sync1_reg <= 2'b00;
		sync2_reg <= 2'b00;
	end else begin
		sync1_reg <= line_in;
		sync2_reg <= sync1_reg;
	end
end

genvar gi;
generate
	for (gi = 0; gi < `TIC_NUM_LINES; gi = gi + 1) begin : g_line
		tic_debounce u_deb (
			.clk_sys(clk_sys),
			.rst_n(rst_n),
			.tick_us(tick_us_reg),
			.line_sync(sync2_reg[gi]),
			.deb_time(deb_time_reg[gi]),
			.line_out_reg(line_db[gi]),
			.edge_out_reg(line_edge[gi])
		);
	end
endgenerate

// ========================================
// trigger delay
// ========================================
localparam ST_IDLE = 1'b0;
localparam ST_WAIT = 1'b1;
reg state_reg;
reg [`TIC_DLY_W-1:0] dly_cnt_reg;
wire free_run = ctrl_reg[`TIC_CTRL_FREE_RUN];
wire src_hw = ctrl_reg[`TIC_CTRL_SRC_HW];
wire acq_en = ctrl_reg[`TIC_CTRL_ACQ_EN];
// hardware trigger is the rising edge of debounced line 1
wire hw_trig = line_edge[0] && src_hw && acq_en && !free_run;
wire sw_trig = sw_trig_reg && !src_hw && acq_en && !free_run;

assign trig_ready = acq_en && !free_run && !frame_busy && state_reg == ST_IDLE;

// a trigger arriving during a pending delay is dropped: one delayed
// trigger is outstanding at most
always @(posedge clk_sys) begin
	if (!rst_n) begin
		state_reg <= ST_IDLE;
		dly_cnt_reg <= {`TIC_DLY_W{1'b0}};
		frame_trigger_reg <= 1'b0;
	end else begin
		frame_trigger_reg <= 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (sw_trig && !frame_busy) begin
					frame_trigger_reg <= 1'b1;
				end else if (hw_trig && !frame_busy) begin
					if (dly_reg == {`TIC_DLY_W{1'b0}}) begin
						frame_trigger_reg <= 1'b1;
					end else begin
						dly_cnt_reg <= {`TIC_DLY_W{1'b0}};
						state_reg <= ST_WAIT;
					end
				end
			end
			ST_WAIT: begin
				if (free_run || !acq_en) begin
					state_reg <= ST_IDLE;
				end else if (dly_cnt_reg > dly_reg) begin
					frame_trigger_reg <= 1'b1;
					state_reg <= ST_IDLE;
				end else if (tick_us_reg) begin
					dly_cnt_reg <= dly_cnt_reg + 1'b1;
				end
			end
			default: state_reg <= ST_IDLE;
		endcase
	end
end

// ready event is the rise of the ready flag
reg ready_d_reg;
always @(posedge clk_sys) begin
	if (!rst_n) begin
		ready_d_reg <= 1'b0;
	end else begin
		ready_d_reg <= trig_ready;
	end
end

assign irq_events = {line_edge[1], line_edge[0], trig_ready && !ready_d_reg, frame_trigger_reg};

endmodule // tic_trigger_cond

// ==== tb/tic_line_src.sv ====
`timescale 1ns/100ps
// ================
// trigger source on both input lines, idle low between pulses
module tic_line_src (
	output logic [1:0] line_in,
	input wire clk_sys
);
	initial line_in = 2'h0;
	task automatic pulse(input int idx, input int len);
		@(posedge clk_sys);
		line_in[idx] <= 1'b1;
		repeat (len) @(posedge clk_sys);
		line_in[idx] <= 1'b0;
	endtask
endmodule // tic_line_src

// ==== tb/tic_trigger_cond_chk.sv ====
`timescale 1ns/100ps
module tic_trigger_cond_chk (
	input wire clk_sys,
	input wire rst_n,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire pready,
	input wire [31:0] prdata,
	input wire pslverr,
	input wire [1:0] line_in,
	input wire frame_busy,
	input wire frame_trigger_reg,
	input wire irq
);
	logic free_q, src_q, acq_q, arm_q;
	logic [1:0] ssel_q;
	logic [31:0] deb_q, mask_q, cnt_q;
	wire wr = psel && penable && pwrite;
	wire rd = psel && penable && !pwrite;
	// arm once line1 held high for the debounce time, one tick of slack for phase
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			{free_q, src_q, acq_q, arm_q, ssel_q} <= 6'h0;
			{deb_q, mask_q, cnt_q} <= 96'h0;
		end else begin
			if (wr && paddr == 12'h000)
				{ssel_q, acq_q, src_q, free_q} <= {pwdata[5:4], pwdata[2:0]};
			if (wr && paddr == 12'h008)
				deb_q <= pwdata;
			if (wr && paddr == 12'h018)
				mask_q <= pwdata;
			cnt_q <= line_in[0] ? cnt_q + 32'h1 : 32'h0;
			if (frame_trigger_reg || (wr && paddr == 12'h008))
				arm_q <= 1'b0;
			else if (cnt_q + 32'h14 >= deb_q * 32'h14)
				arm_q <= 1'b1;
		end
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	no_wait_a: assert property (psel && penable |-> pready) else $error("wait state");
	no_error_a: assert property (psel && penable |-> !pslverr) else $error("error reply");
	trig_pulse_a: assert property (frame_trigger_reg |=> !frame_trigger_reg)
		else $error("long trigger");
	free_run_a: assert property (free_q && $past(free_q) |-> !frame_trigger_reg)
		else $error("trigger in free run");
	unmapped_rd_a: assert property (rd && paddr > 12'h020 |-> prdata == 32'h0)
		else $error("unmapped read");
	status_rd_a: assert property (rd && paddr == 12'h010 && (free_q || !acq_q ||
		ssel_q != 2'h0 || frame_busy && $past(frame_busy)) |-> !prdata[0]) else $error("ready");
	irq_gate_a: assert property (irq |-> mask_q != 32'h0) else $error("irq masked");
	deb_hold_a: assert property (frame_trigger_reg && src_q && !free_q |-> arm_q)
		else $error("early trigger");
endmodule // tic_trigger_cond_chk
bind tic_trigger_cond tic_trigger_cond_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .line_in(line_in),
	.frame_busy(frame_busy), .frame_trigger_reg(frame_trigger_reg), .irq(irq));

// ==== tb/tic_trigger_cond_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fails++; \
	$display("mismatch %0t %h %h", $time, a, b); end end
module tic_trigger_cond_tb_top;
	logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, frame_busy = 0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, q;
	wire pready, pslverr, frame_trigger_reg, irq;
	wire [31:0] prdata;
	wire [1:0] line_in;
	int fails = 0, samples_checked = 0, cyc = 0, tn = 0, tc = 0, c0, n;
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (frame_trigger_reg === 1'b1) begin
			tn <= tn + 1;
			tc <= cyc;
		end
	end
	tic_trigger_cond u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .line_in(line_in), .frame_busy(frame_busy),
		.frame_trigger_reg(frame_trigger_reg), .irq(irq));
	tic_line_src u_src (.clk_sys(clk_sys), .line_in(line_in));
	task automatic ap(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		ap(1'b0, a, 32'h0);
		`CHK(q, e)
	endtask
	// pulse on line1, then trigger count and latency from the rising edge
	task automatic hw(input int len, input int lo, input int hi, input int k);
		n = tn;
		c0 = cyc;
		u_src.pulse(0, len);
		repeat (120) @(posedge clk_sys);
		`CHK(tn, n + k)
		if (k > 0) `CHK(tc - c0 >= lo && tc - c0 <= hi, 1'b1)
	endtask
	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// ================
	// watchdog: the sequence needs well under 1500 cycles
	initial begin
		repeat (5000) @(posedge clk_sys);
		fails++;
		conclude;
	end
	initial begin
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(12'h000, 32'h0);
		rd(12'h040, 32'h0);
		ap(1'b1, 12'h004, 32'h1);
		ap(1'b1, 12'h008, 32'h200000);
		rd(12'h008, 32'hf4240);
		ap(1'b1, 12'h008, 32'h5);
		ap(1'b1, 12'h004, 32'h0);
		ap(1'b1, 12'h008, 32'h2);
		rd(12'h008, 32'h2);
		fork u_src.pulse(1, 170); join_none
		repeat (60) @(posedge clk_sys);
		rd(12'h020, 32'h0);
		repeat (100) @(posedge clk_sys);
		rd(12'h020, 32'h2);
		ap(1'b1, 12'h000, 32'h6);
		hw(19, 0, 0, 0);
		hw(100, 40, 70, 1);
		ap(1'b1, 12'h00c, 32'h3);
		hw(100, 100, 150, 1);
		`CHK(irq, 1'b0)
		ap(1'b1, 12'h018, 32'h1);
		#1 `CHK(irq, 1'b1)
		ap(1'b1, 12'h014, 32'hf);
		#1 `CHK(irq, 1'b0)
		ap(1'b1, 12'h000, 32'h4);
		rd(12'h010, 32'h1);
		n = tn;
		ap(1'b1, 12'h01c, 32'h1);
		repeat (4) @(posedge clk_sys);
		`CHK(tn, n + 1)
		frame_busy <= 1'b1;
		rd(12'h010, 32'h0);
		frame_busy <= 1'b0;
		ap(1'b1, 12'h000, 32'h14);
		rd(12'h010, 32'h0);
		ap(1'b1, 12'h000, 32'h5);
		ap(1'b1, 12'h01c, 32'h1);
		repeat (4) @(posedge clk_sys);
		`CHK(tn, n + 1)
		conclude;
	end
endmodule // tic_trigger_cond_tb_top
